// *** design/sidc_cache_top.sv ***
// split instruction cache and write-through data cache with status word enables
`timescale 1ns/1ps
`default_nettype none
`include "sidc_regs.svh"
module sidc_cache_top
    import sidc_pkg::*;
#(
    parameter logic [0:31] instr_cacheable_low_limit = 32'h00000000,
    parameter logic [0:31] instr_cacheable_high_limit = 32'h00000000,
    parameter logic [0:31] data_cacheable_low_limit = 32'h00000000,
    parameter logic [0:31] data_cacheable_high_limit = 32'h00000000
) (
    input wire logic clk,
    input wire logic rst,
    // machine status word access
    input wire logic mswWrEn,
    input wire logic [0:31] mswWrData,
    output logic [0:31] mswRdData,
    // line write operations and debug writes
    input wire logic instrLineWrEn,
    input wire logic dataLineWrEn,
    input wire logic [0:31] lineAddressOperand,
    input wire logic [0:31] lineWordOperand,
    input wire logic dbgInstrWrEn,
    input wire logic dbgDataWrEn,
    input wire logic [0:31] dbgAddr,
    input wire logic [0:31] dbgWord,
    // fetch unit
    input wire logic fetchReq,
    input wire logic [0:31] fetchAddr,
    output logic fetchReady,
    output logic [0:31] fetchData,
    output logic instrHit,
    // instruction local memory bus
    output logic iLocalReq,
    output logic [0:31] iLocalAddr,
    input wire logic iLocalAck,
    input wire logic [0:31] iLocalData,
    // instruction peripheral bus
    output logic iPeriphReq,
    output logic [0:31] iPeriphAddr,
    output logic iPeriphAbort,
    input wire logic iPeriphAck,
    input wire logic [0:31] iPeriphData,
    // load/store unit
    input wire logic dataReq,
    input wire logic dataWe,
    input wire logic [0:31] dataAddr,
    input wire logic [0:31] dataWrData,
    output logic dataReady,
    output logic [0:31] dataRdData,
    output logic dataHit,
    // data peripheral bus
    output logic dPeriphReq,
    output logic dPeriphWe,
    output logic [0:31] dPeriphAddr,
    output logic [0:31] dPeriphWrData,
    input wire logic dPeriphAck,
    input wire logic [0:31] dPeriphRdData
);
    logic [0:31] msw_r;
    logic icEn;
    logic dcEn;
    sidc_ifsm_type iState_r;
    sidc_dfsm_type dState_r;
    logic [0:31] iAddr_r;
    logic [0:31] dAddr_r;
    logic dWe_r;
    logic [0:31] dWData_r;
    logic iCacheable;
    logic [`SIDC_INDEX_W-1:0] iIdx;
    logic [0:`SIDC_TAG_W-1] iTag;
    logic dCacheable;
    logic [`SIDC_INDEX_W-1:0] dIdx;
    logic [0:`SIDC_TAG_W-1] dTag;
    logic iHitNow;
    logic dHitNow;
    logic iPeriphDone;
    logic iFill;
    logic dStoreUpd;

    sidc_line_if iLines ();
    sidc_line_if dLines ();

    // ----------------------------------------
    // storage and address decoding
    // ----------------------------------------
    sidc_line_store u_instr_store (
        .clk(clk),
        .rst(rst),
        .port(iLines)
    );

    sidc_line_store u_data_store (
        .clk(clk),
        .rst(rst),
        .port(dLines)
    );

    sidc_addr_split #(
        .LOW_LIMIT(instr_cacheable_low_limit),
        .HIGH_LIMIT(instr_cacheable_high_limit)
    ) u_instr_split (
        .addr(iAddr_r),
        .cacheable(iCacheable),
        .idx(iIdx),
        .tag(iTag)
    );

    sidc_addr_split #(
        .LOW_LIMIT(data_cacheable_low_limit),
        .HIGH_LIMIT(data_cacheable_high_limit)
    ) u_data_split (
        .addr(dAddr_r),
        .cacheable(dCacheable),
        .idx(dIdx),
        .tag(dTag)
    );

    // ----------------------------------------
    // machine status word
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msw_r <= `SIDC_MSW_RESET;
        end else if (mswWrEn) begin
            msw_r <= mswWrData;
        end
    end

    assign mswRdData = msw_r;
    assign icEn = msw_r[`SIDC_IC_EN_BIT];
    assign dcEn = msw_r[`SIDC_DC_EN_BIT];

    // ----------------------------------------
    // lookup
    // ----------------------------------------
    // index comes from the request pin while idle so the read lands in the look cycle
    assign iLines.rdIdx = (iState_r == IF_IDLE)
        ? fetchAddr[`SIDC_IDX_BASE +: `SIDC_INDEX_W] : iIdx;
    assign dLines.rdIdx = (dState_r == DF_IDLE) ? dataAddr[`SIDC_IDX_BASE +: `SIDC_INDEX_W] : dIdx;
    // disabled or out-of-window accesses never hit
    assign iHitNow = icEn && iCacheable && iLines.rdValid && (iLines.rdTag == iTag);
    assign dHitNow = dcEn && dCacheable && dLines.rdValid && (dLines.rdTag == dTag);

    // ----------------------------------------
    // instruction fetch sequence
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            iState_r <= IF_IDLE;
            iAddr_r <= '0;
        end else begin
            unique case (iState_r)
                IF_IDLE: begin
                    if (fetchReq) begin
                        iAddr_r <= {fetchAddr[0:29], 2'b00};
                        iState_r <= IF_LOOK;
                    end
                end
                IF_LOOK: begin
                    iState_r <= iHitNow ? IF_IDLE : IF_BOTH;
                end
                IF_BOTH: begin
                    if (iLocalAck || iPeriphAck) begin
                        iState_r <= IF_IDLE;
                    end else begin
                        iState_r <= IF_PB;
                    end
                end
                IF_PB: begin
                    if (iPeriphAck) begin
                        iState_r <= IF_IDLE;
                    end
                end
            endcase
        end
    end

    // bus side of a fetch that missed or was not cacheable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            iLocalReq <= 1'b0;
            iLocalAddr <= '0;
            iPeriphReq <= 1'b0;
            iPeriphAddr <= '0;
            iPeriphAbort <= 1'b0;
        end else begin
            iPeriphAbort <= 1'b0;
            if (iState_r == IF_LOOK && !iHitNow) begin
                iLocalReq <= 1'b1;
                iPeriphReq <= 1'b1;
                iLocalAddr <= iAddr_r;
                iPeriphAddr <= iAddr_r;
            end else if (iState_r == IF_BOTH) begin
                iLocalReq <= 1'b0;
                if (iLocalAck) begin
                    iPeriphReq <= 1'b0;
                    iPeriphAbort <= 1'b1;
                end else if (iPeriphAck) begin
                    iPeriphReq <= 1'b0;
                end
            end else if (iState_r == IF_PB && iPeriphAck) begin
                iPeriphReq <= 1'b0;
            end
        end
    end

    assign iPeriphDone = ((iState_r == IF_BOTH && !iLocalAck) || iState_r == IF_PB) && iPeriphAck;
    // a locked line keeps its contents even though this fetch missed it
    assign iFill = iPeriphDone && icEn && iCacheable && !iLines.rdLock;

    // answer to the fetch unit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetchReady <= 1'b0;
            fetchData <= '0;
            instrHit <= 1'b0;
        end else begin
            fetchReady <= 1'b0;
            instrHit <= 1'b0;
            if (iState_r == IF_LOOK && iHitNow) begin
                fetchReady <= 1'b1;
                instrHit <= 1'b1;
                fetchData <= iLines.rdData;
            end else if (iState_r == IF_BOTH && iLocalAck) begin
                fetchReady <= 1'b1;
                fetchData <= iLocalData;
            end else if (iPeriphDone) begin
                fetchReady <= 1'b1;
                fetchData <= iPeriphData;
            end
        end
    end

    // ----------------------------------------
    // instruction line writes
    // ----------------------------------------
    // operand writes are dropped while enabled so they cannot race a fill
    always_comb begin
        iLines.wrEn = 1'b0;
        iLines.wrIdx = iIdx;
        iLines.wrTag = iTag;
        iLines.wrValid = 1'b1;
        iLines.wrLock = 1'b0;
        iLines.wrData = iPeriphData;
        if (iFill) begin
            iLines.wrEn = 1'b1;
        end else if (dbgInstrWrEn && !icEn) begin
            iLines.wrEn = 1'b1;
            iLines.wrIdx = dbgAddr[`SIDC_IDX_BASE +: `SIDC_INDEX_W];
            iLines.wrTag = dbgAddr[`SIDC_TAG_BASE +: `SIDC_TAG_W];
            iLines.wrValid = dbgAddr[`SIDC_VALID_BIT];
            iLines.wrLock = dbgAddr[`SIDC_LOCK_BIT];
            iLines.wrData = dbgWord;
        end else if (instrLineWrEn && !icEn) begin
            iLines.wrEn = 1'b1;
            iLines.wrIdx = lineAddressOperand[`SIDC_IDX_BASE +: `SIDC_INDEX_W];
            iLines.wrTag = lineAddressOperand[`SIDC_TAG_BASE +: `SIDC_TAG_W];
            iLines.wrValid = lineAddressOperand[`SIDC_VALID_BIT];
            iLines.wrLock = lineAddressOperand[`SIDC_LOCK_BIT];
            iLines.wrData = lineWordOperand;
        end
    end

    // ----------------------------------------
    // load/store sequence
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dState_r <= DF_IDLE;
            dAddr_r <= '0;
            dWe_r <= 1'b0;
            dWData_r <= '0;
        end else begin
            unique case (dState_r)
                DF_IDLE: begin
                    if (dataReq) begin
                        dAddr_r <= {dataAddr[0:29], 2'b00};
                        dWe_r <= dataWe;
                        dWData_r <= dataWrData;
                        dState_r <= DF_LOOK;
                    end
                end
                DF_LOOK: begin
                    dState_r <= (!dWe_r && dHitNow) ? DF_IDLE : DF_BUS;
                end
                DF_BUS: begin
                    if (dPeriphAck) begin
                        dState_r <= DF_IDLE;
                    end
                end
            endcase
        end
    end

    // every store and every load miss goes to the peripheral bus
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dPeriphReq <= 1'b0;
            dPeriphWe <= 1'b0;
            dPeriphAddr <= '0;
            dPeriphWrData <= '0;
        end else if (dState_r == DF_LOOK && (dWe_r || !dHitNow)) begin
            dPeriphReq <= 1'b1;
            dPeriphWe <= dWe_r;
            dPeriphAddr <= dAddr_r;
            dPeriphWrData <= dWData_r;
        end else if (dState_r == DF_BUS && dPeriphAck) begin
            dPeriphReq <= 1'b0;
            dPeriphWe <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dataReady <= 1'b0;
            dataRdData <= '0;
            dataHit <= 1'b0;
        end else begin
            dataReady <= 1'b0;
            dataHit <= 1'b0;
            if (dState_r == DF_LOOK && !dWe_r && dHitNow) begin
                dataReady <= 1'b1;
                dataHit <= 1'b1;
                dataRdData <= dLines.rdData;
            end else if (dState_r == DF_BUS && dPeriphAck) begin
                dataReady <= 1'b1;
                if (!dWe_r) begin
                    dataRdData <= dPeriphRdData;
                end
            end
        end
    end

    // ----------------------------------------
    // data line writes
    // ----------------------------------------
    // a store may refresh a locked line of its own tag but never evict one
    assign dStoreUpd = (dState_r == DF_LOOK) && dWe_r && dcEn && dCacheable
        && (!dLines.rdLock || (dLines.rdValid && dLines.rdTag == dTag));

    always_comb begin
        dLines.wrEn = 1'b0;
        dLines.wrIdx = dIdx;
        dLines.wrTag = dTag;
        dLines.wrValid = 1'b1;
        dLines.wrLock = dLines.rdLock;
        dLines.wrData = dWData_r;
        if (dStoreUpd) begin
            dLines.wrEn = 1'b1;
        end else if (dbgDataWrEn && !dcEn) begin
            dLines.wrEn = 1'b1;
            dLines.wrIdx = dbgAddr[`SIDC_IDX_BASE +: `SIDC_INDEX_W];
            dLines.wrTag = dbgAddr[`SIDC_TAG_BASE +: `SIDC_TAG_W];
            dLines.wrValid = dbgAddr[`SIDC_VALID_BIT];
            dLines.wrLock = dbgAddr[`SIDC_LOCK_BIT];
            dLines.wrData = dbgWord;
        end else if (dataLineWrEn && !dcEn) begin
            dLines.wrEn = 1'b1;
            dLines.wrIdx = lineAddressOperand[`SIDC_IDX_BASE +: `SIDC_INDEX_W];
            dLines.wrTag = lineAddressOperand[`SIDC_TAG_BASE +: `SIDC_TAG_W];
            dLines.wrValid = lineAddressOperand[`SIDC_VALID_BIT];
            dLines.wrLock = lineAddressOperand[`SIDC_LOCK_BIT];
            dLines.wrData = lineWordOperand;
        end
    end
    // enable bits gate only lookups and updates, never the stored lines
endmodule // sidc_cache_top
`default_nettype wire

// *** inc/sidc_regs.svh ***
// constants for the split instruction/data cache: bit positions, widths, reset values
`ifndef SIDC_REGS_SVH
`define SIDC_REGS_SVH

// bits are numbered big-endian: bit 0 is the most significant
`define SIDC_WORD_W 32
// line-index width, legal range 9 to 14 (2 to 64 Kbytes)
`define SIDC_INDEX_W 9
`define SIDC_INDEX_MIN 9
`define SIDC_INDEX_MAX 14
// tag width, any size that fits above the line index
`define SIDC_TAG_W 16
// first (most significant) bit of the line-index field
`define SIDC_IDX_BASE (30 - `SIDC_INDEX_W)
// first (most significant) bit of the tag field
`define SIDC_TAG_BASE (`SIDC_IDX_BASE - `SIDC_TAG_W)
`define SIDC_LINES (1 << `SIDC_INDEX_W)

// status word enable bits
`define SIDC_IC_EN_BIT 26
`define SIDC_DC_EN_BIT 24
`define SIDC_MSW_RESET 32'h00000000

// line address operand flag bits
`define SIDC_LOCK_BIT 31
`define SIDC_VALID_BIT 30

`endif

// *** inc/sidc_pkg.sv ***
// types shared by the split cache modules
package sidc_pkg;
    typedef enum {
        IF_IDLE,
        IF_LOOK,
        IF_BOTH,
        IF_PB
    } sidc_ifsm_type;

    typedef enum {
        DF_IDLE,
        DF_LOOK,
        DF_BUS
    } sidc_dfsm_type;
endpackage

// *** inc/sidc_line_if.sv ***
// read and write port of one direct-mapped line store
`timescale 1ns/1ps
`default_nettype none
`include "sidc_regs.svh"
interface sidc_line_if;
    logic [`SIDC_INDEX_W-1:0] rdIdx;
    logic [0:`SIDC_TAG_W-1] rdTag;
    logic rdValid;
    logic rdLock;
    logic [0:31] rdData;
    logic wrEn;
    logic [`SIDC_INDEX_W-1:0] wrIdx;
    logic [0:`SIDC_TAG_W-1] wrTag;
    logic wrValid;
    logic wrLock;
    logic [0:31] wrData;

    modport store (
        input rdIdx, wrEn, wrIdx, wrTag, wrValid, wrLock, wrData,
        output rdTag, rdValid, rdLock, rdData
    );
    modport user (
        output rdIdx, wrEn, wrIdx, wrTag, wrValid, wrLock, wrData,
        input rdTag, rdValid, rdLock, rdData
    );
endinterface
`default_nettype wire

// *** design/sidc_line_store.sv ***
// direct-mapped line store: tag, valid, lock and one data word per line
`timescale 1ns/1ps
`default_nettype none
`include "sidc_regs.svh"
module sidc_line_store
    import sidc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    sidc_line_if.store port
);
    logic [0:`SIDC_TAG_W-1] tagMem [`SIDC_LINES];
    logic [0:31] dataMem [`SIDC_LINES];
    logic [`SIDC_LINES-1:0] validVec_r;
    logic [`SIDC_LINES-1:0] lockVec_r;

    // ----------------------------------------
    // flags: cleared at reset, untouched by the enable bits
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            validVec_r <= '0;
            lockVec_r <= '0;
        end else if (port.wrEn) begin
            validVec_r[port.wrIdx] <= port.wrValid;
            lockVec_r[port.wrIdx] <= port.wrLock;
        end
    end

    // ----------------------------------------
    // tag and data arrays, no reset so they map to block memory
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (port.wrEn) begin
            tagMem[port.wrIdx] <= port.wrTag;
            dataMem[port.wrIdx] <= port.wrData;
        end
    end

    // registered read, one cycle after the index is presented
    always_ff @(posedge clk) begin
        port.rdTag <= tagMem[port.rdIdx];
        port.rdData <= dataMem[port.rdIdx];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port.rdValid <= 1'b0;
            port.rdLock <= 1'b0;
        end else begin
            port.rdValid <= validVec_r[port.rdIdx];
            port.rdLock <= lockVec_r[port.rdIdx];
        end
    end
endmodule // sidc_line_store
`default_nettype wire

// *** design/sidc_addr_split.sv ***
// splits a word address into tag and line index and checks the cacheable window
`timescale 1ns/1ps
`default_nettype none
`include "sidc_regs.svh"
module sidc_addr_split
    import sidc_pkg::*;
#(
    parameter logic [0:31] LOW_LIMIT = 32'h00000000,
    parameter logic [0:31] HIGH_LIMIT = 32'h00000000
) (
    input wire logic [0:31] addr,
    output logic cacheable,
    output logic [`SIDC_INDEX_W-1:0] idx,
    output logic [0:`SIDC_TAG_W-1] tag
);
    logic [0:31] wordAddr;

    assign wordAddr = {addr[0:29], 2'b00};
    assign cacheable = (wordAddr >= LOW_LIMIT) && (wordAddr <= HIGH_LIMIT);
    // bits above the tag field are looked at only by the window check
    assign idx = wordAddr[`SIDC_IDX_BASE +: `SIDC_INDEX_W];
    assign tag = wordAddr[`SIDC_TAG_BASE +: `SIDC_TAG_W];
endmodule // sidc_addr_split
`default_nettype wire

// *** testbench/sidc_cache_monitor.sv ***
// checker: port-level assertions for the split cache
`timescale 1ns/1ps
`default_nettype none
module sidc_cache_monitor
    import sidc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic mswWrEn,
    input wire logic [0:31] mswWrData,
    input wire logic [0:31] mswRdData,
    input wire logic fetchReady,
    input wire logic [0:31] fetchData,
    input wire logic instrHit,
    input wire logic iLocalReq,
    input wire logic iLocalAck,
    input wire logic [0:31] iLocalData,
    input wire logic iPeriphReq,
    input wire logic iPeriphAbort,
    input wire logic iPeriphAck,
    input wire logic [0:31] iPeriphData,
    input wire logic dataReady,
    input wire logic dataHit,
    input wire logic dPeriphReq,
    input wire logic dPeriphAck
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // hit answers come from a lookup made while enabled
    chk_ihit_ready: assert property (
        instrHit |-> fetchReady && $past(mswRdData[26])) else $error("bad instruction hit");
    chk_dhit_ready: assert property (
        dataHit |-> dataReady && $past(mswRdData[24])) else $error("bad data hit");
    chk_local_abort: assert property (
        iLocalReq && iLocalAck |=> fetchReady && iPeriphAbort && !iPeriphReq
        && fetchData == $past(iLocalData)) else $error("local ack not taken");
    chk_both_buses: assert property (
        $rose(iLocalReq) |-> iPeriphReq) else $error("buses not requested together");
    chk_local_pulse: assert property (
        iLocalReq |=> !iLocalReq) else $error("local request too long");
    chk_ifill_done: assert property (
        iPeriphReq && iPeriphAck |=> fetchReady && !instrHit
        && fetchData == $past(iPeriphData)) else $error("fetch miss answer wrong");
    chk_load_done: assert property (
        dPeriphReq && dPeriphAck |=> dataReady && !dataHit) else $error("bus access answer wrong");
    chk_load_wait: assert property (
        dPeriphReq && !dPeriphAck |=> !dataReady) else $error("ready before bus ack");
    chk_msw_write: assert property (
        mswWrEn |=> mswRdData == $past(mswWrData)) else $error("status word not written");
endmodule // sidc_cache_monitor
bind sidc_cache_top sidc_cache_monitor mon (.clk, .rst, .mswWrEn, .mswWrData, .mswRdData,
    .fetchReady, .fetchData, .instrHit, .iLocalReq, .iLocalAck, .iLocalData, .iPeriphReq,
    .iPeriphAbort, .iPeriphAck, .iPeriphData, .dataReady, .dataHit, .dPeriphReq, .dPeriphAck);
`default_nettype wire

// *** testbench/sidc_bus_model.sv ***
// bus partner: local memory and the two peripheral buses
`timescale 1ns/1ps
`default_nettype none
module sidc_bus_model
    import sidc_pkg::*;
#(
    parameter logic [0:31] LOCAL_TOP = 32'h0001_0000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] lat,
    input wire logic iLocalReq,
    input wire logic [0:31] iLocalAddr,
    output logic iLocalAck,
    output logic [0:31] iLocalData,
    input wire logic iPeriphReq,
    input wire logic [0:31] iPeriphAddr,
    output logic iPeriphAck,
    output logic [0:31] iPeriphData,
    input wire logic dPeriphReq,
    input wire logic [0:31] dPeriphAddr,
    output logic dPeriphAck,
    output logic [0:31] dPeriphRdData
);
    logic iAck_r, dAck_r;
    logic [3:0] iCnt_r, dCnt_r;
    function automatic logic [0:31] memWord(input logic [0:31] a);
        return a ^ 32'h5A5A_5A5A;
    endfunction
    // local memory lies below both windows
    assign iLocalAck = iLocalReq && iLocalAddr < LOCAL_TOP;
    // idle data lines show the inverse so a stale word never matches
    assign iLocalData = iLocalAck ? memWord(iLocalAddr) : ~memWord(iLocalAddr);
    assign iPeriphAck = iAck_r && iPeriphReq;
    assign iPeriphData = iPeriphAck ? memWord(iPeriphAddr) : ~memWord(iPeriphAddr);
    assign dPeriphAck = dAck_r && dPeriphReq;
    assign dPeriphRdData = dPeriphAck ? memWord(dPeriphAddr) : ~memWord(dPeriphAddr);
    // ack after lat+1 waits; an aborted request just clears the count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            iAck_r <= 1'b0;
            dAck_r <= 1'b0;
            iCnt_r <= 4'h0;
            dCnt_r <= 4'h0;
        end else begin
            iAck_r <= iPeriphReq && !iAck_r && iCnt_r == lat;
            dAck_r <= dPeriphReq && !dAck_r && dCnt_r == lat;
            iCnt_r <= (iPeriphReq && !iAck_r) ? iCnt_r + 4'h1 : 4'h0;
            dCnt_r <= (dPeriphReq && !dAck_r) ? dCnt_r + 4'h1 : 4'h0;
        end
    end
endmodule // sidc_bus_model
`default_nettype wire

// *** testbench/tb.sv ***
// testbench: fetch, load/store and line-write sequences
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [0:31] IC_ON = 32'h0000_0020;
    localparam logic [0:31] DC_ON = 32'h0000_0080;
    logic clk, rst, mswWrEn, fetchReq, dataReq, dataWe;
    logic instrLineWrEn, dataLineWrEn, dbgInstrWrEn, dbgDataWrEn;
    logic [3:0] lat;
    logic [0:31] mswWrData, lineAddressOperand, lineWordOperand, dbgAddr, dbgWord;
    logic [0:31] fetchAddr, dataAddr, dataWrData, wrD;
    logic fetchReady, instrHit, iLocalReq, iLocalAck, iPeriphReq, iPeriphAbort, iPeriphAck;
    logic dataReady, dataHit, dPeriphReq, dPeriphWe, dPeriphAck;
    logic [0:31] mswRdData, fetchData, iLocalAddr, iLocalData, iPeriphAddr, iPeriphData;
    logic [0:31] dataRdData, dPeriphAddr, dPeriphWrData, dPeriphRdData;
    int numErrors, cmpCount, cycles;
    logic [0:31] winTab [4] = '{32'h0000_FFFC, 32'h0001_0000, 32'hF801_FFFC, 32'hF802_0000};
    logic [0:3] winHit = 4'b0110;
    sidc_cache_top #(
        .instr_cacheable_low_limit(32'h0001_0000), .instr_cacheable_high_limit(32'hF801_FFFF),
        .data_cacheable_low_limit(32'h0002_0000), .data_cacheable_high_limit(32'h0002_0FFF)
    ) uut (.clk, .rst, .mswWrEn, .mswWrData, .mswRdData, .instrLineWrEn, .dataLineWrEn,
        .lineAddressOperand, .lineWordOperand, .dbgInstrWrEn, .dbgDataWrEn, .dbgAddr, .dbgWord,
        .fetchReq, .fetchAddr, .fetchReady, .fetchData, .instrHit, .iLocalReq, .iLocalAddr,
        .iLocalAck, .iLocalData, .iPeriphReq, .iPeriphAddr, .iPeriphAbort, .iPeriphAck,
        .iPeriphData, .dataReq, .dataWe, .dataAddr, .dataWrData, .dataReady, .dataRdData,
        .dataHit, .dPeriphReq, .dPeriphWe, .dPeriphAddr, .dPeriphWrData, .dPeriphAck,
        .dPeriphRdData);
    sidc_bus_model pm (.clk, .rst, .lat, .iLocalReq, .iLocalAddr, .iLocalAck, .iLocalData,
        .iPeriphReq, .iPeriphAddr, .iPeriphAck, .iPeriphData, .dPeriphReq, .dPeriphAddr,
        .dPeriphAck, .dPeriphRdData);
    always #12.5 clk = ~clk;
    always @(posedge clk) if (dPeriphReq && dPeriphAck && dPeriphWe) wrD <= dPeriphWrData;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            numErrors++;
            stopTest();
        end
    end
    function automatic logic [0:31] mw(input logic [0:31] a);
        return a ^ 32'h5A5A_5A5A;
    endfunction
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        cmpCount++;
        if (g !== e) begin
            numErrors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic msw(input logic [0:31] v);
        mswWrData = v;
        mswWrEn = 1'b1;
        @(posedge clk) #1 mswWrEn = 1'b0;
        @(posedge clk) #1 chk({2'b0, mswRdData}, {2'b0, v});
    endtask
    task automatic lineWrite(input int k, input logic [0:31] a, input logic [0:31] w);
        {lineAddressOperand, dbgAddr, lineWordOperand, dbgWord} = {a, a, w, w};
        {instrLineWrEn, dataLineWrEn, dbgInstrWrEn, dbgDataWrEn} = 4'h8 >> k;
        @(posedge clk) #1 {instrLineWrEn, dataLineWrEn, dbgInstrWrEn, dbgDataWrEn} = 4'h0;
        @(posedge clk) #1;
    endtask
    task automatic fetch(input logic [0:31] a, input logic h, input logic [0:31] d);
        int n;
        fetchAddr = a;
        fetchReq = 1'b1;
        @(posedge clk) #1 fetchReq = 1'b0;
        for (n = 0; n < 40 && fetchReady !== 1'b1; n++) @(posedge clk) #1;
        chk({fetchReady, instrHit, fetchData}, {1'b1, h, d});
        @(posedge clk) #1;
    endtask
    task automatic dacc(input logic we, input logic [0:31] a, input logic [0:31] wd,
        input logic h, input logic [0:31] d);
        int n;
        {dataWe, dataAddr, dataWrData} = {we, a, wd};
        dataReq = 1'b1;
        @(posedge clk) #1 dataReq = 1'b0;
        for (n = 0; n < 40 && dataReady !== 1'b1; n++) @(posedge clk) #1;
        chk({dataReady, dataHit, we ? wrD : dataRdData}, {1'b1, h, d});
        @(posedge clk) #1;
    endtask
    task automatic stopTest();
        $display("errors %0d comparisons %0d", numErrors, cmpCount);
        if (numErrors == 0 && cmpCount > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {clk, rst, lat, mswWrEn, fetchReq, dataReq, dataWe} = 10'h100;
        {instrLineWrEn, dataLineWrEn, dbgInstrWrEn, dbgDataWrEn} = 4'h0;
        {mswWrData, lineAddressOperand, lineWordOperand, dbgAddr, dbgWord} = '0;
        {fetchAddr, dataAddr, dataWrData} = '0;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        chk({2'b0, mswRdData}, 34'h0);
        fetch(32'h0001_0040, 1'b0, mw(32'h0001_0040));
        msw(IC_ON | DC_ON);
        fetch(32'h0001_0040, 1'b0, mw(32'h0001_0040));
        fetch(32'h0001_0040, 1'b1, mw(32'h0001_0040));
        for (int i = 0; i < 4; i++) begin
            fetch(winTab[i], 1'b0, mw(winTab[i]));
            fetch(winTab[i], winHit[i], mw(winTab[i]));
        end
        fetch(32'h0001_0840, 1'b0, mw(32'h0001_0840));
        fetch(32'h0801_0840, 1'b1, mw(32'h0001_0840));
        fetch(32'h0001_0040, 1'b0, mw(32'h0001_0040));
        msw(DC_ON);
        fetch(32'h0001_0040, 1'b0, mw(32'h0001_0040));
        msw(IC_ON | DC_ON);
        fetch(32'h0001_0040, 1'b1, mw(32'h0001_0040));
        msw(32'h0);
        lineWrite(0, 32'h0001_2003, 32'hCAFE_0001);
        lineWrite(1, 32'h0002_0102, 32'h5555_AAAA);
        lineWrite(2, 32'h0001_4102, 32'h1234_5678);
        lineWrite(3, 32'h0002_0202, 32'h0BAD_F00D);
        msw(IC_ON | DC_ON);
        fetch(32'h0001_2000, 1'b1, 32'hCAFE_0001);
        fetch(32'h0001_2800, 1'b0, mw(32'h0001_2800));
        fetch(32'h0001_2000, 1'b1, 32'hCAFE_0001);
        fetch(32'h0001_4100, 1'b1, 32'h1234_5678);
        lat = 4'h5;
        fetch(32'h0001_5000, 1'b0, mw(32'h0001_5000));
        dacc(1'b0, 32'h0002_0100, 32'h0, 1'b1, 32'h5555_AAAA);
        dacc(1'b0, 32'h0002_0200, 32'h0, 1'b1, 32'h0BAD_F00D);
        dacc(1'b1, 32'h0002_0300, 32'hDEAD_BEEF, 1'b0, 32'hDEAD_BEEF);
        dacc(1'b0, 32'h0002_0302, 32'h0, 1'b1, 32'hDEAD_BEEF);
        msw(IC_ON);
        dacc(1'b0, 32'h0002_0300, 32'h0, 1'b0, mw(32'h0002_0300));
        msw(IC_ON | DC_ON);
        dacc(1'b0, 32'h0002_0400, 32'h0, 1'b0, mw(32'h0002_0400));
        dacc(1'b0, 32'h0002_0400, 32'h0, 1'b0, mw(32'h0002_0400));
        dacc(1'b1, 32'h0002_1000, 32'h1111_2222, 1'b0, 32'h1111_2222);
        dacc(1'b0, 32'h0002_1000, 32'h0, 1'b0, mw(32'h0002_1000));
        stopTest();
    end
endmodule // tb
`default_nettype wire
